// ### logic/port_cfg_pkg.sv
// Summary of operation
// - page-load instruction stores its immediate operand in the page select register
// - low three page bits pick one of eight 16-nibble indirect pages
// - set enable bit lets a change on input pin n wake or interrupt
// - mode bit 0 sets first bidir port push-pull (0) or open-drain (1)
// - mode bit 1 sets second bidir port push-pull (0) or open-drain (1)
// - mode bit 2 set enables pull-ups of the first input port
// - mode bit 3 set enables pull-ups of the second input port
// - first direction register bit n: 0 output, 1 input, per pin
// - first direction register resets to all ones, all inputs
// - second direction register bit n: 0 output, 1 input, per pin
// - second direction register resets to all ones, all inputs
package port_cfg_pkg;
    localparam int NIB_W = 4;
    localparam int PAGE_SEL_W = 3;
    localparam int RAM_ADDR_W = 7;
    // load selector codes
    localparam logic [2:0] LD_PAGE = 3'h0;
    localparam logic [2:0] LD_PIN_CHG = 3'h1;
    localparam logic [2:0] LD_MODE = 3'h2;
    localparam logic [2:0] LD_DIR_A = 3'h3;
    localparam logic [2:0] LD_DIR_B = 3'h4;
    // mode register fields
    localparam int MODE_A_OD = 0;
    localparam int MODE_B_OD = 1;
    localparam int MODE_C_PU = 2;
    localparam int MODE_D_PU = 3;
    // reset values
    localparam logic [3:0] PAGE_RST = 4'h0;
    localparam logic [3:0] PIN_CHG_RST = 4'h0;
    localparam logic [3:0] MODE_RST = 4'h0;
    localparam logic [3:0] DIR_RST = 4'hf;
endpackage : port_cfg_pkg

// ### logic/cfg_nibble_reg.sv
`timescale 1ns/1ps
module cfg_nibble_reg #(
    parameter logic [3:0] RST_VAL = 4'h0
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // load
    input wire logic load_i,
    input wire logic [3:0] data_i,
    // stored value
    output logic [3:0] value_o
);
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            value_o <= RST_VAL;
        end else if (load_i) begin
            value_o <= data_i;
        end
    end
endmodule : cfg_nibble_reg

// ### logic/port_config_and_page_select.sv
`timescale 1ns/1ps
module port_config_and_page_select (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // immediate load from the core
    input wire logic load_i,
    input wire logic [2:0] load_sel_i,
    input wire logic [3:0] load_data_i,
    // indirect addressing
    input wire logic [3:0] indirect_offset_i,
    output logic [6:0] indirect_addr_o,
    output logic [2:0] ram_page_o,
    // pin change detection, first input port
    input wire logic [3:0] first_input_port_i,
    output logic [3:0] pin_change_o,
    output logic pin_change_any_o,
    // port modes
    output logic first_bidir_open_drain_o,
    output logic second_bidir_open_drain_o,
    output logic first_input_pullup_o,
    output logic second_input_pullup_o,
    output logic [3:0] first_bidir_dir_o,
    output logic [3:0] second_bidir_dir_o
);
    // ****************************************
    // decode
    // ****************************************
    function automatic logic sel_hit(input logic ld, input logic [2:0] s, input logic [2:0] c);
        sel_hit = ld && (s == c);
    endfunction : sel_hit

    logic [3:0] ram_page_select;
    logic [3:0] pin_change_enable;
    logic [3:0] port_drive_pullup_mode;
    logic [3:0] first_bidir_direction;
    logic [3:0] second_bidir_direction;

    // ****************************************
    // configuration registers
    // ****************************************
    cfg_nibble_reg #(.RST_VAL(port_cfg_pkg::PAGE_RST)) u_page (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .load_i(sel_hit(load_i, load_sel_i, port_cfg_pkg::LD_PAGE)),
        .data_i(load_data_i),
        .value_o(ram_page_select)
    );
    cfg_nibble_reg #(.RST_VAL(port_cfg_pkg::PIN_CHG_RST)) u_pin_chg (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .load_i(sel_hit(load_i, load_sel_i, port_cfg_pkg::LD_PIN_CHG)),
        .data_i(load_data_i),
        .value_o(pin_change_enable)
    );
    cfg_nibble_reg #(.RST_VAL(port_cfg_pkg::MODE_RST)) u_mode (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .load_i(sel_hit(load_i, load_sel_i, port_cfg_pkg::LD_MODE)),
        .data_i(load_data_i),
        .value_o(port_drive_pullup_mode)
    );
    cfg_nibble_reg #(.RST_VAL(port_cfg_pkg::DIR_RST)) u_dir_a (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .load_i(sel_hit(load_i, load_sel_i, port_cfg_pkg::LD_DIR_A)),
        .data_i(load_data_i),
        .value_o(first_bidir_direction)
    );
    cfg_nibble_reg #(.RST_VAL(port_cfg_pkg::DIR_RST)) u_dir_b (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .load_i(sel_hit(load_i, load_sel_i, port_cfg_pkg::LD_DIR_B)),
        .data_i(load_data_i),
        .value_o(second_bidir_direction)
    );

    // ****************************************
    // mode outputs
    // ****************************************
    always_comb begin
        ram_page_o = ram_page_select[port_cfg_pkg::PAGE_SEL_W-1:0];
        first_bidir_open_drain_o = port_drive_pullup_mode[port_cfg_pkg::MODE_A_OD];
        second_bidir_open_drain_o = port_drive_pullup_mode[port_cfg_pkg::MODE_B_OD];
        first_input_pullup_o = port_drive_pullup_mode[port_cfg_pkg::MODE_C_PU];
        second_input_pullup_o = port_drive_pullup_mode[port_cfg_pkg::MODE_D_PU];
        first_bidir_dir_o = first_bidir_direction;
        second_bidir_dir_o = second_bidir_direction;
        indirect_addr_o = {ram_page_o, indirect_offset_i};
    end

    // ****************************************
    // pin change detection
    // ****************************************
    logic [3:0] pin_sync1_q;
    logic [3:0] pin_sync2_q;
    logic [3:0] pin_prev_q;
    logic [3:0] pin_chg_d;
    logic [3:0] pin_chg_q;
    logic pin_chg_any_q;

    // no reset: chain tracks the pins through reset, so release brings no false edge
    always_ff @(posedge clk_sys_i) begin
        pin_sync1_q <= first_input_port_i;
        pin_sync2_q <= pin_sync1_q;
        pin_prev_q <= pin_sync2_q;
    end

    assign pin_chg_d = (pin_sync2_q ^ pin_prev_q) & pin_change_enable;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pin_chg_q <= 4'h0;
            pin_chg_any_q <= 1'h0;
        end else begin
            pin_chg_q <= pin_chg_d;
            pin_chg_any_q <= |pin_chg_d;
        end
    end

    assign pin_change_o = pin_chg_q;
    assign pin_change_any_o = pin_chg_any_q;
endmodule : port_config_and_page_select

// ### verification/port_cfg_properties.sv
`timescale 1ns/1ps
module port_cfg_checker (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // immediate load
    input wire logic load_i,
    input wire logic [2:0] load_sel_i,
    input wire logic [3:0] load_data_i,
    // indirect addressing
    input wire logic [3:0] indirect_offset_i,
    input wire logic [6:0] indirect_addr_o,
    input wire logic [2:0] ram_page_o,
    // pin change
    input wire logic [3:0] pin_change_o,
    input wire logic pin_change_any_o,
    // port modes
    input wire logic first_bidir_open_drain_o,
    input wire logic second_bidir_open_drain_o,
    input wire logic first_input_pullup_o,
    input wire logic second_input_pullup_o,
    input wire logic [3:0] first_bidir_dir_o,
    input wire logic [3:0] second_bidir_dir_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    chk_page_load: assert property (load_i && load_sel_i == 3'h0 |=>
        ram_page_o == $past(load_data_i[2:0])) else $error("page load");
    chk_page_hold: assert property (!(load_i && load_sel_i == 3'h0) |=>
        $stable(ram_page_o)) else $error("page drift");
    chk_addr_map: assert property ({ram_page_o, indirect_offset_i} ==
        indirect_addr_o) else $error("address map");
    chk_dira_load: assert property (load_i && load_sel_i == 3'h3 |=>
        first_bidir_dir_o == $past(load_data_i)) else $error("dir a load");
    chk_dirb_load: assert property (load_i && load_sel_i == 3'h4 |=>
        second_bidir_dir_o == $past(load_data_i)) else $error("dir b load");
    chk_dir_reset: assert property (disable iff (1'b0) rst_i |=>
        {first_bidir_dir_o, second_bidir_dir_o} == 8'hff) else $error("dir reset");
    chk_dira_hold: assert property (!(load_i && load_sel_i == 3'h3) |=>
        $stable(first_bidir_dir_o)) else $error("dir a drift");
    chk_dirb_hold: assert property (!(load_i && load_sel_i == 3'h4) |=>
        $stable(second_bidir_dir_o)) else $error("dir b drift");
    chk_mode_load: assert property (load_i && load_sel_i == 3'h2 |=>
        {second_input_pullup_o, first_input_pullup_o, second_bidir_open_drain_o,
        first_bidir_open_drain_o} == $past(load_data_i)) else $error("mode load");
    chk_mode_hold: assert property (!(load_i && load_sel_i == 3'h2) |=>
        $stable({second_input_pullup_o, first_input_pullup_o, second_bidir_open_drain_o,
        first_bidir_open_drain_o})) else $error("mode drift");
    chk_any_change: assert property (pin_change_any_o == |pin_change_o)
        else $error("any change");
    cov_refused: cover property (load_i && load_sel_i > 3'h4);
    cov_pin_change: cover property (pin_change_any_o);
    cov_page_top: cover property (ram_page_o == 3'h7);
    cov_dir_out: cover property (first_bidir_dir_o == 4'h0);
endmodule : port_cfg_checker
bind port_config_and_page_select port_cfg_checker u_chk (.*);

// ### verification/pin_driver_model.sv
`timescale 1ns/1ps
module pin_driver_model (
    input wire logic clk_sys_i,
    input wire logic [3:0] level_i,
    output logic [3:0] pins_o
);
    always_ff @(posedge clk_sys_i) pins_o <= level_i;
endmodule : pin_driver_model

// ### verification/port_config_and_page_select_tb_top.sv
`timescale 1ns/1ps
module port_config_and_page_select_tb_top;
    logic clk_sys_i = 1'h0, rst_i, load_i, pin_change_any_o, first_bidir_open_drain_o;
    logic second_bidir_open_drain_o, first_input_pullup_o, second_input_pullup_o;
    logic [2:0] load_sel_i, ram_page_o;
    logic [3:0] load_data_i, indirect_offset_i, first_input_port_i, pin_change_o, t, acc;
    logic [3:0] first_bidir_dir_o, second_bidir_dir_o, level, m[5] = '{0, 0, 0, 15, 15};
    logic [6:0] indirect_addr_o;
    int fails = 0, total_checks = 0, hits = 0;
    wire logic [11:0] pag = {2'h0, ram_page_o, indirect_addr_o};
    wire logic [11:0] cfg = {second_input_pullup_o, first_input_pullup_o, second_bidir_open_drain_o,
        first_bidir_open_drain_o, first_bidir_dir_o, second_bidir_dir_o};
    port_config_and_page_select dut (.*);
    pin_driver_model far (.clk_sys_i(clk_sys_i), .level_i(level), .pins_o(first_input_port_i));
    initial forever #4 clk_sys_i = ~clk_sys_i;
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
        fails += int'(got !== exp);
    endtask : chk
    task automatic step(input int sel, input int data);
        @(posedge clk_sys_i);
        #1 chk(pag, {2'h0, m[0][2:0], m[0][2:0], indirect_offset_i});
        chk(cfg, {m[2], m[3], m[4]});
        {load_i, load_sel_i, load_data_i} = {1'h1, 3'(sel), 4'(data)};
        indirect_offset_i = 4'($urandom);
        if (sel < 5) m[sel] = 4'(data);
    endtask : step
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    initial begin
        {rst_i, load_i, load_sel_i, load_data_i, indirect_offset_i, level} = 17'h10000;
        void'($urandom(31));
        repeat (16) @(posedge clk_sys_i);
        #1 rst_i = 1'h0;
        for (int i = 0; i < 80; i++) step($urandom % 8, $urandom % 16);
        for (int p = 0; p < 6; p++) begin
            step(1, p == 0 ? 0 : $urandom % 16);
            step(7, 0);
            {t, acc} = {4'($urandom), 4'h0};
            hits = 0;
            level = level ^ t;
            repeat (8) @(negedge clk_sys_i) begin
                acc = acc | pin_change_o;
                hits += int'(pin_change_any_o === 1'h1);
            end
            chk(12'(acc), 12'(m[1] & t));
            chk(12'(hits), 12'(|(m[1] & t)));
        end
        @(posedge clk_sys_i);
        #1 {rst_i, load_i} = 2'h2;
        repeat (2) @(posedge clk_sys_i);
        #1 rst_i = 1'h0;
        m = '{4'h0, 4'h0, 4'h0, 4'hf, 4'hf};
        for (int i = 0; i < 20; i++) step($urandom % 8, $urandom % 16);
        print_verdict();
    end
endmodule : port_config_and_page_select_tb_top
